// [wsc_pkg.sv]
`default_nettype none
package wsc_pkg;
    localparam int TW = 40;
    localparam int FW = 32;
    localparam int AW = 16;
    localparam int DW = 7;

    typedef enum logic [2:0] {
        FN_SINE = 3'b000, FN_SQUARE = 3'b001, FN_RAMP = 3'b010, FN_PULSE = 3'b011,
        FN_NOISE = 3'b100, FN_DC = 3'b101, FN_ARB = 3'b110
    } wsc_func_t;

    typedef enum logic [1:0] {UN_VPP = 2'b00, UN_VRMS = 2'b01, UN_DBM = 2'b10} wsc_units_t;

    typedef enum logic [2:0] {
        MD_NONE = 3'b000, MD_AM = 3'b001, MD_FM = 3'b010, MD_PM = 3'b011,
        MD_FSK = 3'b100, MD_PWM = 3'b101, MD_SWEEP = 3'b110, MD_BURST = 3'b111
    } wsc_mode_t;

    typedef enum logic [4:0] {
        P_FUNC = 5'h00, P_UNITS = 5'h01, P_FREQ = 5'h02, P_PERIOD = 5'h03, P_WIDTH = 5'h04,
        P_PDUTY = 5'h05, P_EDGE = 5'h06, P_AMP = 5'h07, P_OFFSET = 5'h08, P_FMDEV = 5'h09,
        P_PWMDEV = 5'h0a, P_PWMDDEV = 5'h0b, P_SQDUTY = 5'h0c, P_SWSTART = 5'h0d,
        P_SWSTOP = 5'h0e, P_MARKER = 5'h0f, P_MODE = 5'h10
    } wsc_param_t;

    // Frequencies in Hz, times in ns, levels in mV (mVrms for rms and dBm units), duties in percent.
    typedef struct packed {
        wsc_func_t func;
        wsc_units_t units;
        wsc_mode_t mode;
        logic [FW-1:0] freq;
        logic [TW-1:0] period;
        logic [TW-1:0] width;
        logic [DW-1:0] pduty;
        logic [TW-1:0] edge_t;
        logic [AW-1:0] amp;
        logic signed [AW-1:0] offset;
        logic [FW-1:0] fm_dev;
        logic [TW-1:0] pwm_dev;
        logic [DW-1:0] pwm_ddev;
        logic [DW-1:0] sq_duty;
        logic [FW-1:0] sw_start;
        logic [FW-1:0] sw_stop;
        logic [FW-1:0] marker;
    } wsc_cfg_t;

    localparam int NR = 12;
    localparam int R_EDGE = 0;
    localparam int R_WIDTH = 1;
    localparam int R_PERIOD = 2;
    localparam int R_AMP = 3;
    localparam int R_OFFSET = 4;
    localparam int R_FM_CAR = 5;
    localparam int R_FM_MAX = 6;
    localparam int R_PWM = 7;
    localparam int R_SQDUTY = 8;
    localparam int R_MARKER = 9;
    localparam int R_MODE = 10;
    localparam int R_EDGE_DUTY = 11;

    localparam logic [15:0] ERR_SETTINGS = 16'hff23;

    localparam logic [TW-1:0] EDGE_MIN_NS = 40'h00_0000_0005;
    localparam logic [TW-1:0] WIDTH_MIN_NS = 40'h00_0000_0014;
    localparam logic [63:0] EDGE_NUM = 64'h5;
    localparam logic [63:0] EDGE_DEN = 64'h8;
    localparam logic [63:0] DUTY_EDGE_DEN = 64'h320;
    localparam logic [63:0] PCT_EDGE = 64'ha0;
    localparam logic [DW-1:0] PCT_FULL = 7'h64;

    localparam logic [AW-1:0] RMS_LIM_SINE = 16'h0dd0;
    localparam logic [AW-1:0] RMS_LIM_SQUARE = 16'h1388;
    localparam logic [AW-1:0] RMS_LIM_RAMP = 16'h0b47;
    localparam logic [AW-1:0] RMS_LIM_OTHER = 16'h1388;
    localparam logic [31:0] CREST_SINE = 32'h0b0c;
    localparam logic [31:0] CREST_SQUARE = 32'h07d0;
    localparam logic [31:0] CREST_RAMP = 32'h0d88;
    localparam logic [31:0] CREST_DIV = 32'h03e8;
    localparam logic [AW-1:0] VMAX_MV = 16'h1388;

    localparam logic [FW-1:0] FMAX_SINE_SQ = 32'h0132_b3a0;
    localparam logic [FW-1:0] FMAX_RAMP = 32'h0004_93e0;
    localparam logic [FW-1:0] FMAX_ARB = 32'h004d_d1e0;
    localparam logic [FW-1:0] SQ_FREQ_SPLIT = 32'h0098_9680;
    localparam logic [DW-1:0] SQ_LO_SLOW = 7'h14;
    localparam logic [DW-1:0] SQ_HI_SLOW = 7'h50;
    localparam logic [DW-1:0] SQ_LO_FAST = 7'h28;
    localparam logic [DW-1:0] SQ_HI_FAST = 7'h3c;

    localparam wsc_cfg_t CFG_RESET = '{
        func: FN_SINE, units: UN_VPP, mode: MD_NONE, freq: 32'h0000_03e8,
        period: 40'h00_000f_4240, width: 40'h00_0001_86a0, pduty: 7'h0a,
        edge_t: 40'h00_0000_0005, amp: 16'h0064, offset: 16'h0000, fm_dev: 32'h0000_0064,
        pwm_dev: 40'h00_0000_2710, pwm_ddev: 7'h01, sq_duty: 7'h32,
        sw_start: 32'h0000_0064, sw_stop: 32'h0000_03e8, marker: 32'h0000_01f4
    };
endpackage
`default_nettype wire

// [wsc_clamp.sv]
// Overview of operation
// RULE_01: Invalid pulse: shrink edge time first, then width or duty, lastly lengthen period. Code fits on period or width writes only, never shrinks duty.
// RULE_02: New pulse duty: edge time kept below 0.625 x period x duty / 100.
// RULE_03: Rms or dBm units: function change clamps amplitude to crest limit, sine 3.536 Vrms.
// RULE_04: In dc function the output level comes from offset alone, amplitude ignored.
// RULE_05: Leaving dc function adjusts offset to fit the current amplitude.
// RULE_06: With FM on, deviation is lowered so carrier stays at least deviation.
// RULE_07: Carrier plus deviation limited to 20.1 MHz, 300 kHz or 5.1 MHz by function. Code only lowers deviation, to zero when the carrier alone exceeds it.
// RULE_08: PWM width or duty deviation fits within width or duty, edge and period.
// RULE_09: Square duty 20-80% up to 10 MHz, 40-60% above; frequency change clamps.
// RULE_10: Sweep marker forced between sweep start and stop frequencies.
// RULE_11: Each automatic adjustment raises error -221 with a reason naming the change.
// RULE_12: Only one modulation, sweep or burst mode active; enabling one turns others off.
`timescale 1ns/1ps
`default_nettype none
module wsc_clamp (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_wr,
    input wire wsc_pkg::wsc_param_t i_sel,
    input wire logic [wsc_pkg::TW-1:0] i_val,
    output wsc_pkg::wsc_cfg_t o_cfg,
    output logic [wsc_pkg::AW-1:0] o_out_amp,
    output logic signed [wsc_pkg::AW-1:0] o_out_offset,
    output logic o_conflict,
    output logic [15:0] o_err_code,
    output logic [wsc_pkg::NR-1:0] o_reason
);
    import wsc_pkg::*;

    wsc_cfg_t cfg_r, cfg_nxt;
    logic [NR-1:0] reason_r, reason_nxt;
    logic [15:0] err_r, err_nxt;
    logic [AW-1:0] out_amp_r, out_amp_nxt;

    logic [63:0] t64, lim64, e16;
    logic [AW-1:0] rms_lim, vlim;
    logic [31:0] crest, vpp32;
    logic [FW-1:0] fmax, swlo, swhi;
    logic [DW-1:0] dlo, dhi, epct, dmax;
    logic [TW-1:0] emax, wdmax;
    logic [AW-1:0] off_abs;
    wsc_cfg_t c;
    logic [NR-1:0] m;

    always_comb begin
        c = cfg_r;
        m = '0;
        t64 = '0;
        lim64 = '0;
        e16 = '0;
        emax = '0;
        wdmax = '0;
        epct = '0;
        dmax = '0;
        vlim = '0;
        off_abs = '0;
        if (i_wr) begin
            case (i_sel)
                P_FUNC: c.func = wsc_func_t'(i_val[2:0]);
                P_UNITS: c.units = wsc_units_t'(i_val[1:0]);
                P_FREQ: c.freq = i_val[FW-1:0];
                P_PERIOD: c.period = i_val;
                P_WIDTH: c.width = i_val;
                P_PDUTY: c.pduty = i_val[DW-1:0];
                P_EDGE: c.edge_t = i_val;
                P_AMP: c.amp = i_val[AW-1:0];
                P_OFFSET: c.offset = i_val[AW-1:0];
                P_FMDEV: c.fm_dev = i_val[FW-1:0];
                P_PWMDEV: c.pwm_dev = i_val;
                P_PWMDDEV: c.pwm_ddev = i_val[DW-1:0];
                P_SQDUTY: c.sq_duty = i_val[DW-1:0];
                P_SWSTART: c.sw_start = i_val[FW-1:0];
                P_SWSTOP: c.sw_stop = i_val[FW-1:0];
                P_MARKER: c.marker = i_val[FW-1:0];
                P_MODE: begin
                    // A single mode field holds the active mode, so enabling one turns the old one off.
                    // Switching every mode off is a plain request and is not reported as a conflict.
                    c.mode = wsc_mode_t'(i_val[2:0]);
                    m[R_MODE] = (cfg_r.mode != MD_NONE) && (c.mode != MD_NONE) && (c.mode != cfg_r.mode); // RULE_12
                end
                default: c = cfg_r;
            endcase
        end

        // Pulse fit: edge first, then width, then period.
        if (i_wr && (i_sel == P_PERIOD || i_sel == P_WIDTH)) begin
            e16 = ({24'h0, c.edge_t} * 64'h8) / 64'h5;
            if ({24'h0, c.width} + e16 > {24'h0, c.period}) begin
                t64 = (c.period > c.width) ? ({24'h0, c.period - c.width} * EDGE_NUM) / EDGE_DEN : 64'h0;
                emax = (t64[TW-1:0] < EDGE_MIN_NS) ? EDGE_MIN_NS : t64[TW-1:0];
                if (c.edge_t > emax) begin
                    c.edge_t = emax; // RULE_01
                    m[R_EDGE] = 1'b1;
                end
                e16 = ({24'h0, c.edge_t} * 64'h8) / 64'h5;
                if ({24'h0, c.width} + e16 > {24'h0, c.period}) begin
                    lim64 = ({24'h0, c.period} > e16) ? {24'h0, c.period} - e16 : 64'h0;
                    if (lim64 >= {24'h0, WIDTH_MIN_NS}) begin
                        c.width = lim64[TW-1:0]; // RULE_01
                        m[R_WIDTH] = 1'b1;
                    end else begin
                        t64 = {24'h0, c.width} + e16;
                        c.period = t64[TW-1:0]; // RULE_01
                        m[R_PERIOD] = 1'b1;
                    end
                end
            end
        end

        if (i_wr && i_sel == P_PDUTY) begin
            t64 = ({24'h0, c.period} * {57'h0, c.pduty} * EDGE_NUM) / DUTY_EDGE_DEN;
            emax = (t64[TW-1:0] > EDGE_MIN_NS) ? t64[TW-1:0] - 40'h1 : EDGE_MIN_NS;
            if (c.edge_t > emax) begin
                c.edge_t = emax; // RULE_02
                m[R_EDGE_DUTY] = 1'b1;
            end
        end

        // Rms and dBm amplitudes are both held in mVrms, so one limit table serves both units.
        case (c.func)
            FN_SINE: rms_lim = RMS_LIM_SINE;
            FN_SQUARE: rms_lim = RMS_LIM_SQUARE;
            FN_RAMP: rms_lim = RMS_LIM_RAMP;
            default: rms_lim = RMS_LIM_OTHER;
        endcase
        if (c.func != cfg_r.func && c.units != UN_VPP && c.amp > rms_lim) begin
            c.amp = rms_lim; // RULE_03
            m[R_AMP] = 1'b1;
        end

        case (c.func)
            FN_SINE: crest = CREST_SINE;
            FN_RAMP: crest = CREST_RAMP;
            default: crest = CREST_SQUARE;
        endcase
        vpp32 = (c.units == UN_VPP) ? {16'h0, c.amp} : ({16'h0, c.amp} * crest) / CREST_DIV;
        if (cfg_r.func == FN_DC && c.func != FN_DC) begin
            // Half the swing is rounded up so an odd Vpp never leaves the offset half a millivolt too large.
            vlim = (vpp32 < {15'h0, VMAX_MV, 1'b0}) ? VMAX_MV - AW'((vpp32 + 32'h1) >> 1) : '0;
            off_abs = c.offset[AW-1] ? AW'(-c.offset) : c.offset;
            if (off_abs > vlim) begin
                c.offset = c.offset[AW-1] ? AW'(-vlim) : vlim; // RULE_05
                m[R_OFFSET] = 1'b1;
            end
        end

        // The carrier rule applies only while FM is on; the maximum-frequency limit is checked in every mode by lowering deviation, never the carrier.
        if (c.mode == MD_FM && c.fm_dev > c.freq) begin
            c.fm_dev = c.freq; // RULE_06
            m[R_FM_CAR] = 1'b1;
        end
        case (c.func)
            FN_RAMP: fmax = FMAX_RAMP;
            FN_ARB: fmax = FMAX_ARB;
            default: fmax = FMAX_SINE_SQ;
        endcase
        if ({1'b0, c.freq} + {1'b0, c.fm_dev} > {1'b0, fmax}) begin
            c.fm_dev = (fmax > c.freq) ? fmax - c.freq : '0; // RULE_07
            m[R_FM_MAX] = 1'b1;
        end

        e16 = ({24'h0, c.edge_t} * 64'h8) / 64'h5;
        lim64 = ({24'h0, c.period} > {24'h0, c.width} + e16) ? {24'h0, c.period} - {24'h0, c.width} - e16 : 64'h0;
        wdmax = (lim64 < {24'h0, c.width}) ? lim64[TW-1:0] : c.width;
        t64 = (c.period == '0) ? {57'h0, PCT_FULL} : ({24'h0, c.edge_t} * PCT_EDGE + {24'h0, c.period} - 64'h1) / {24'h0, c.period};
        epct = (t64 > {57'h0, PCT_FULL}) ? PCT_FULL : t64[DW-1:0];
        // The sum is one bit wider so a large duty plus edge share cannot wrap and hide the overflow.
        dmax = ({1'b0, PCT_FULL} > {1'b0, c.pduty} + {1'b0, epct}) ? PCT_FULL - c.pduty - epct : '0;
        dmax = (dmax < c.pduty) ? dmax : c.pduty;
        if (c.pwm_dev > wdmax) begin
            c.pwm_dev = wdmax; // RULE_08
            m[R_PWM] = 1'b1;
        end
        if (c.pwm_ddev > dmax) begin
            c.pwm_ddev = dmax; // RULE_08
            m[R_PWM] = 1'b1;
        end

        // The duty window narrows above the split frequency, so a frequency write can pull the duty in.
        dlo = (c.freq > SQ_FREQ_SPLIT) ? SQ_LO_FAST : SQ_LO_SLOW;
        dhi = (c.freq > SQ_FREQ_SPLIT) ? SQ_HI_FAST : SQ_HI_SLOW;
        if (c.func == FN_SQUARE && (c.sq_duty > dhi || c.sq_duty < dlo)) begin
            c.sq_duty = (c.sq_duty > dhi) ? dhi : dlo; // RULE_09
            m[R_SQDUTY] = 1'b1;
        end

        // Start may lie above stop, so the span runs from whichever of the two is lower.
        swlo = (c.sw_start < c.sw_stop) ? c.sw_start : c.sw_stop;
        swhi = (c.sw_start < c.sw_stop) ? c.sw_stop : c.sw_start;
        if (c.marker < swlo || c.marker > swhi) begin
            c.marker = (c.marker < swlo) ? swlo : swhi; // RULE_10
            m[R_MARKER] = 1'b1;
        end

        cfg_nxt = c;
        reason_nxt = m;
        err_nxt = (|m) ? ERR_SETTINGS : 16'h0000; // RULE_11
        // The driven amplitude is registered so the dc blanking leaves the block straight from a flop.
        out_amp_nxt = (c.func == FN_DC) ? '0 : c.amp; // RULE_04
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            cfg_r <= CFG_RESET;
            reason_r <= '0;
            err_r <= 16'h0000;
            out_amp_r <= CFG_RESET.amp;
        end else begin
            cfg_r <= cfg_nxt;
            reason_r <= reason_nxt;
            err_r <= err_nxt;
            out_amp_r <= out_amp_nxt;
        end
    end

    assign o_cfg = cfg_r;
    assign o_out_amp = out_amp_r;
    assign o_out_offset = cfg_r.offset;
    assign o_conflict = |reason_r;
    assign o_err_code = err_r;
    assign o_reason = reason_r;
endmodule // wsc_clamp
`default_nettype wire

// [wsc_clamp_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module wsc_clamp_asserts (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_wr,
    input wire wsc_pkg::wsc_param_t i_sel,
    input wire logic [wsc_pkg::TW-1:0] i_val,
    input wire wsc_pkg::wsc_cfg_t o_cfg,
    input wire logic [wsc_pkg::AW-1:0] o_out_amp,
    input wire logic signed [wsc_pkg::AW-1:0] o_out_offset,
    input wire logic o_conflict,
    input wire logic [15:0] o_err_code,
    input wire logic [wsc_pkg::NR-1:0] o_reason
);
    import wsc_pkg::*;
    logic [FW-1:0] fmax;
    logic [FW-1:0] mk_lo;
    logic [FW-1:0] mk_hi;
    logic fast;
    assign fmax = (o_cfg.func == FN_RAMP) ? FMAX_RAMP : (o_cfg.func == FN_ARB) ? FMAX_ARB : FMAX_SINE_SQ;
    assign mk_lo = (o_cfg.sw_start < o_cfg.sw_stop) ? o_cfg.sw_start : o_cfg.sw_stop;
    assign mk_hi = (o_cfg.sw_start < o_cfg.sw_stop) ? o_cfg.sw_stop : o_cfg.sw_start;
    assign fast = o_cfg.freq > SQ_FREQ_SPLIT;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    sequence s_fm_wr;
        i_wr && (i_sel == P_FREQ || i_sel == P_FMDEV);
    endsequence
    sequence s_mode_swap;
        i_wr && i_sel == P_MODE && o_cfg.mode != MD_NONE && i_val[2:0] != MD_NONE && i_val[2:0] != o_cfg.mode;
    endsequence
    property p_err;
        o_conflict |-> o_err_code == ERR_SETTINGS && o_reason != '0;
    endproperty
    a_err: assert property (p_err) else $error("conflict without code");
    property p_dc_out;
        o_cfg.func == FN_DC |-> o_out_amp == '0 && o_out_offset == o_cfg.offset;
    endproperty
    a_dc_out: assert property (p_dc_out) else $error("dc level not from offset");
    property p_sq;
        i_wr && i_sel == P_FREQ && o_cfg.func == FN_SQUARE
        |=> o_cfg.sq_duty <= (fast ? SQ_HI_FAST : SQ_HI_SLOW) && o_cfg.sq_duty >= (fast ? SQ_LO_FAST : SQ_LO_SLOW);
    endproperty
    a_sq: assert property (p_sq) else $error("square duty out of range");
    property p_mk;
        i_wr |=> o_cfg.marker >= mk_lo && o_cfg.marker <= mk_hi;
    endproperty
    a_mk: assert property (p_mk) else $error("marker outside span");
    property p_fm_max;
        s_fm_wr |=> o_cfg.freq > fmax || {1'b0, o_cfg.freq} + o_cfg.fm_dev <= {1'b0, fmax};
    endproperty
    a_fm_max: assert property (p_fm_max) else $error("deviation above maximum");
    property p_fm_car;
        i_wr && i_sel == P_FREQ && o_cfg.mode == MD_FM |=> o_cfg.fm_dev <= o_cfg.freq;
    endproperty
    a_fm_car: assert property (p_fm_car) else $error("deviation above carrier");
    property p_mode;
        s_mode_swap |=> o_conflict && o_reason[R_MODE] && o_cfg.mode == $past(i_val[2:0]);
    endproperty
    a_mode: assert property (p_mode) else $error("mode swap not reported");
    property p_duty;
        i_wr && i_sel == P_PDUTY
        |=> o_cfg.edge_t == EDGE_MIN_NS || EDGE_NUM * o_cfg.period * o_cfg.pduty > DUTY_EDGE_DEN * o_cfg.edge_t;
    endproperty
    a_duty: assert property (p_duty) else $error("edge too long for duty");
    property p_crest;
        i_wr && i_sel == P_FUNC && o_cfg.units != UN_VPP && i_val[2:0] != o_cfg.func
        |=> o_cfg.amp <= (o_cfg.func == FN_SINE ? RMS_LIM_SINE : o_cfg.func == FN_SQUARE ? RMS_LIM_SQUARE
            : o_cfg.func == FN_RAMP ? RMS_LIM_RAMP : RMS_LIM_OTHER);
    endproperty
    a_crest: assert property (p_crest) else $error("rms amplitude above limit");
    property p_dc_exit;
        i_wr && i_sel == P_FUNC && o_cfg.func == FN_DC && i_val[2:0] != FN_DC && o_cfg.units == UN_VPP
        |=> 2 * (o_cfg.offset < 0 ? -int'(o_cfg.offset) : int'(o_cfg.offset)) + int'(o_cfg.amp) <= 2 * int'(VMAX_MV);
    endproperty
    a_dc_exit: assert property (p_dc_exit) else $error("offset unfit after dc exit");
endmodule // wsc_clamp_asserts
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import wsc_pkg::*;
    logic i_mclk, i_reset_n, i_wr;
    wsc_param_t i_sel;
    logic [TW-1:0] i_val;
    wsc_cfg_t o_cfg;
    logic [AW-1:0] o_out_amp;
    logic signed [AW-1:0] o_out_offset;
    logic o_conflict;
    logic [15:0] o_err_code;
    logic [NR-1:0] o_reason;
    int n_fail = 0;
    int total_checks = 0;
    wsc_clamp i_wsc_clamp (.i_mclk, .i_reset_n, .i_wr, .i_sel, .i_val, .o_cfg, .o_out_amp, .o_out_offset,
        .o_conflict, .o_err_code, .o_reason);
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    task automatic conclude();
        $display("mismatches %0d of %0d checks", n_fail, total_checks);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [TW-1:0] got, input logic [TW-1:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %0h want %0h", $time, got, exp);
        end
    endtask
    // A negative bit index means no adjustment is expected.
    task automatic chk_flag(input int b);
        logic ok;
        ok = (b < 0) ? (o_conflict === 1'b0 && o_err_code === 16'h0000)
            : (o_conflict === 1'b1 && o_err_code === ERR_SETTINGS && o_reason[b] === 1'b1);
        total_checks++;
        if (!ok) begin
            n_fail++;
            $display("BAD %0t flag %0b code %0h reason %0h", $time, o_conflict, o_err_code, o_reason);
        end
    endtask
    task automatic wr(input wsc_param_t s, input logic [TW-1:0] v);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_sel <= s;
        i_val <= v;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        #1;
    endtask
    initial begin
        repeat (1000) @(posedge i_mclk);
        n_fail++;
        conclude();
    end
    initial begin
        i_reset_n = 1'b0;
        i_wr = 1'b0;
        i_sel = P_FUNC;
        i_val = '0;
        repeat (20) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        #1;
        chk(o_cfg.period, 40'hf4240);
        chk(o_cfg.sq_duty, 40'h32);
        chk_flag(-1);
        wr(P_FUNC, FN_SQUARE);
        wr(P_SQDUTY, 40'h46);
        wr(P_FREQ, 40'he4e1c0);
        chk(o_cfg.sq_duty, 40'h3c);
        chk_flag(R_SQDUTY);
        @(posedge i_mclk);
        #1;
        chk_flag(-1);
        wr(P_FMDEV, 40'h989680);
        chk(o_cfg.fm_dev, 40'h4dd1e0);
        chk_flag(R_FM_MAX);
        wr(P_MODE, MD_AM);
        wr(P_MODE, MD_FM);
        chk_flag(R_MODE);
        wr(P_FREQ, 40'hf4240);
        chk(o_cfg.fm_dev, 40'hf4240);
        chk_flag(R_FM_CAR);
        for (int m = 1; m < 8; m++) begin
            wr(P_MODE, 40'(m));
            chk_flag(R_MODE);
        end
        wr(P_MODE, MD_NONE);
        chk_flag(-1);
        wr(P_UNITS, UN_VRMS);
        wr(P_AMP, 40'h1388);
        wr(P_FUNC, FN_SINE);
        chk(o_cfg.amp, 40'hdd0);
        chk_flag(R_AMP);
        wr(P_UNITS, UN_VPP);
        wr(P_AMP, 40'hfa0);
        wr(P_FUNC, FN_DC);
        chk(o_out_amp, 40'h0);
        wr(P_OFFSET, 40'hf060);
        chk(o_out_offset, 40'hff_ffff_f060);
        wr(P_FUNC, FN_SINE);
        chk(o_cfg.offset, 40'hff_ffff_f448);
        chk_flag(R_OFFSET);
        chk(o_out_amp, 40'hfa0);
        wr(P_FUNC, FN_PULSE);
        wr(P_PERIOD, 40'hf4240);
        wr(P_WIDTH, 40'h186a0);
        wr(P_EDGE, 40'h2710);
        wr(P_PDUTY, 40'h1);
        chk(o_cfg.edge_t, 40'h1869);
        chk_flag(R_EDGE_DUTY);
        wr(P_WIDTH, 40'h4e20);
        wr(P_PERIOD, 40'h61a8);
        chk(o_cfg.edge_t, 40'hc35);
        chk(o_cfg.width, 40'h4e20);
        chk_flag(R_EDGE);
        wr(P_PWMDEV, 40'h9c40);
        chk(o_cfg.pwm_dev, 40'h0);
        chk_flag(R_PWM);
        wr(P_WIDTH, 40'h61a8);
        chk(o_cfg.edge_t, 40'h5);
        chk(o_cfg.width, 40'h61a0);
        chk_flag(R_WIDTH);
        wr(P_PERIOD, 40'h14);
        chk(o_cfg.period, 40'h61a8);
        chk_flag(R_PERIOD);
        wr(P_MARKER, 40'h32);
        chk(o_cfg.marker, 40'h64);
        chk_flag(R_MARKER);
        wr(P_MARKER, 40'h7d0);
        chk(o_cfg.marker, 40'h3e8);
        wr(P_UNITS, UN_DBM);
        wr(P_FUNC, FN_RAMP);
        chk(o_cfg.amp, 40'hb47);
        chk_flag(R_AMP);
        chk(o_cfg.fm_dev, 40'h0);
        wr(P_FUNC, FN_ARB);
        wr(P_FMDEV, 40'h4c4b40);
        chk(o_cfg.fm_dev, 40'h3e8fa0);
        chk_flag(R_FM_MAX);
        conclude();
    end
endmodule // tb_top
bind wsc_clamp wsc_clamp_asserts i_wsc_clamp_asserts (.i_mclk, .i_reset_n, .i_wr, .i_sel, .i_val, .o_cfg,
    .o_out_amp, .o_out_offset, .o_conflict, .o_err_code, .o_reason);
`default_nettype wire
